// [design/apsf_consts.vh]
`ifndef APSF_CONSTS_VH
`define APSF_CONSTS_VH

// Register word indices on the plain register port
`define APSF_REG_BUF_FIRST 5'h00
`define APSF_REG_BUF_LAST 5'h0F
`define APSF_REG_CTRL 5'h10
`define APSF_REG_CFG 5'h11
`define APSF_REG_PINCFG 5'h12
`define APSF_REG_PORT 5'h13

// Control register field positions
`define APSF_CTRL_ON_BIT 15
`define APSF_CTRL_SIDL_BIT 13
`define APSF_CTRL_FMT_HI 9
`define APSF_CTRL_FMT_LO 8
`define APSF_CTRL_SAMP_BIT 1
`define APSF_CTRL_DONE_BIT 0

// Configuration register field positions
`define APSF_CFG_RC_BIT 7
`define APSF_CFG_CH_HI 3
`define APSF_CFG_CH_LO 0

// Reset values
`define APSF_CTRL_RST 16'h0000
`define APSF_CFG_RST 8'h00
`define APSF_PINCFG_RST 16'h0000

// Read formats
`define APSF_FMT_INT 2'h0
`define APSF_FMT_SINT 2'h1
`define APSF_FMT_FRAC 2'h2
`define APSF_FMT_SFRAC 2'h3

// Timing counts
`define APSF_CONV_TADS 4'hE
`define APSF_RC_START_CYCLES 4'h1

`endif

// [design/apsf_fmt.v]
`timescale 1ns/1ps
`include "apsf_consts.vh"

module apsf_fmt (
    input wire [11:0] raw,
    input wire [1:0] read_format_sel,
    output reg [15:0] bus_word
);

    always @* begin
        case (read_format_sel)
            `APSF_FMT_INT: begin
                bus_word = {4'h0, raw}; // RL13
            end
            `APSF_FMT_SINT: begin
                bus_word = {{4{raw[11]}}, raw}; // RL13
            end
            `APSF_FMT_FRAC: begin
                bus_word = {raw, 4'h0}; // RL13
            end
            `APSF_FMT_SFRAC: begin
                // Same bit image as fractional; bit 15 is the sign
                bus_word = {raw, 4'h0}; // RL19
            end
            default: begin
                bus_word = 16'h0000;
            end
        endcase
    end

endmodule

// [design/apsf_ctrl.v]
`timescale 1ns/1ps
`include "apsf_consts.vh"

// Function
// RL1 - Converter on bit powers the block; off disables digital and analog parts.
// RL2 - Software waits for analog settling after turning the converter on.
// RL3 - In Sleep every converter clock but the RC clock stops and is held low.
// RL4 - Sleep during a conversion not clocked by RC aborts it; it never resumes.
// RL5 - Sleep entry and exit leave all register contents unchanged.
// RL6 - RC clock keeps running in Sleep; conversion starts one cycle late.
// RL7 - A conversion finished during Sleep sets the completion flag.
// RL8 - After Sleep conversion: wake if interrupt enabled, else power down silently.
// RL9 - In Idle the converter runs unless stop-in-idle is set.
// RL10 - Reset clears registers, turns converter off, aborts sampling and conversion.
// RL11 - Reset leaves result buffer words untouched; undefined after power-on.
// RL12 - Results are 12 bits; a 2-bit field picks one of four read formats.
// RL13 - Reads give 16 bits: zero, sign-extended, or left-justified with zeros.
// RL14 - Writes to result storage are always right-justified integers.
// RL15 - Port data reads return zero for every analog-configured pin.
// RL16 - A digital-configured pin is never converted as an analog channel.
// RL17 - Caller completes full sampling after a channel change before converting.
// RL18 - Aborted conversions never reach storage; last good value is kept.
// RL19 - Format codes: integer, signed integer, fractional, signed fractional.
// RL20 - In Off mode triggers are ignored and no completion is flagged.

module apsf_ctrl (
    input wire ref_clk,
    input wire rst,
    input wire clk_en,
    input wire [4:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire tcy_tick,
    input wire rc_osc,
    input wire cpu_sleep,
    input wire cpu_idle,
    input wire irq_enable,
    input wire conv_trigger,
    input wire [11:0] conv_result,
    input wire [15:0] port_pins,
    output reg analog_power_en,
    output reg hold_capacitor,
    output reg conv_clk,
    output reg [3:0] channel_sel,
    output reg done_pulse,
    output reg wake_req
);

    localparam ST_IDLE = 2'h0;
    localparam ST_SAMPLE = 2'h1;
    localparam ST_DELAY = 2'h2;
    localparam ST_CONVERT = 2'h3;

    localparam [15:0] CTRL_RESET = `APSF_CTRL_RST;
    localparam [7:0] CFG_RESET = `APSF_CFG_RST;

    reg converter_on;
    reg stop_in_idle;
    reg [1:0] read_format_sel;
    reg samp;
    reg done;
    reg rc_clock_select;
    reg [3:0] mux_a_channel_sel;
    reg [15:0] analog_pin_config;
    reg [1:0] state;
    reg [3:0] tad_count;
    reg [3:0] wr_ptr;
    reg sleep_off;
    reg rc_s1;
    reg rc_s2;
    reg rc_s3;
    reg [15:0] pin_s1;
    reg [15:0] pin_s2;
    reg [11:0] result_buffer [0:15];

    reg [1:0] next_state;
    reg [3:0] next_tad_count;
    reg next_done_evt;
    reg [15:0] ctrl_word;
    reg [15:0] cfg_word;

    wire [15:0] fmt_word;
    wire wr_ctrl;
    wire wr_cfg;
    wire wr_pincfg;
    wire wr_buf;
    wire rc_tick;
    wire sleep_gated;
    wire idle_halt;
    wire active;
    wire conv_tick;
    wire samp_start;
    wire samp_end;
    wire ch_is_digital;
    wire [11:0] store_value;
    wire on_eff;
    wire buf_wr_en;
    wire [3:0] buf_wr_index;
    wire [11:0] buf_wr_data;

    // Buffer words share one address decode for reads and writes
    function is_buf_addr;
        input [4:0] addr;
        begin
            is_buf_addr = (addr <= `APSF_REG_BUF_LAST);
        end
    endfunction

    assign wr_ctrl = reg_wr && (reg_addr == `APSF_REG_CTRL);
    assign wr_cfg = reg_wr && (reg_addr == `APSF_REG_CFG);
    assign wr_pincfg = reg_wr && (reg_addr == `APSF_REG_PINCFG);
    assign wr_buf = reg_wr && is_buf_addr(reg_addr);

    // Only the second and third stages feed the edge detect
    assign rc_tick = rc_s2 && !rc_s3;

    // Without the RC source all converter clocks die in Sleep
    assign sleep_gated = cpu_sleep && !rc_clock_select; // RL3
    assign idle_halt = cpu_idle && stop_in_idle && !cpu_sleep; // RL9
    // A control write acts in its own cycle, so one write can switch
    // the converter on and start sampling
    assign on_eff = wr_ctrl ? reg_wdata[`APSF_CTRL_ON_BIT] : converter_on;
    assign active = on_eff && !sleep_off; // RL1
    assign conv_tick = rc_clock_select ? rc_tick : tcy_tick;

    // Sampling starts only on a software request, so an aborted
    // sequence cannot pick up again by itself
    assign samp_start = wr_ctrl && reg_wdata[`APSF_CTRL_SAMP_BIT];
    assign samp_end = conv_trigger ||
        (wr_ctrl && !reg_wdata[`APSF_CTRL_SAMP_BIT]);

    assign ch_is_digital = analog_pin_config[mux_a_channel_sel];
    // A digital pin yields zero rather than a conversion
    assign store_value = ch_is_digital ? 12'h000 : conv_result; // RL16

    always @* begin
        next_state = state;
        next_tad_count = tad_count;
        next_done_evt = 1'b0;
        if (!active || sleep_gated) begin
            next_state = ST_IDLE; // RL4
            next_tad_count = 4'h0;
        end else if (idle_halt) begin
            next_state = state; // RL9
        end else begin
            case (state)
                ST_IDLE: begin
                    if (samp_start) begin
                        next_state = ST_SAMPLE; // RL20
                    end
                end
                ST_SAMPLE: begin
                    if (samp_end) begin
                        next_tad_count = 4'h0;
                        if (rc_clock_select) begin
                            next_state = ST_DELAY; // RL6
                        end else begin
                            next_state = ST_CONVERT;
                        end
                    end
                end
                ST_DELAY: begin
                    if (tcy_tick) begin
                        if (tad_count == `APSF_RC_START_CYCLES - 4'h1) begin
                            next_state = ST_CONVERT; // RL6
                            next_tad_count = 4'h0;
                        end else begin
                            next_tad_count = tad_count + 4'h1;
                        end
                    end
                end
                ST_CONVERT: begin
                    if (conv_tick) begin
                        if (tad_count == `APSF_CONV_TADS - 4'h1) begin
                            next_state = ST_IDLE;
                            next_tad_count = 4'h0;
                            next_done_evt = 1'b1;
                        end else begin
                            next_tad_count = tad_count + 4'h1;
                        end
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    // One write port: a finished conversion beats a software write
    assign buf_wr_en = next_done_evt || wr_buf; // RL18
    assign buf_wr_index = next_done_evt ? wr_ptr : reg_addr[3:0];
    assign buf_wr_data = next_done_evt ? store_value : reg_wdata[11:0]; // RL14

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rc_s1 <= 1'b0;
            rc_s2 <= 1'b0;
            rc_s3 <= 1'b0;
            pin_s1 <= 16'h0000;
            pin_s2 <= 16'h0000;
        end else if (clk_en) begin
            rc_s1 <= rc_osc;
            rc_s2 <= rc_s1;
            rc_s3 <= rc_s2;
            pin_s1 <= port_pins;
            pin_s2 <= pin_s1;
        end
    end

    // Sleep touches none of these, only the sequencer state
    always @(posedge ref_clk or posedge rst) begin // RL5
        if (rst) begin
            converter_on <= CTRL_RESET[`APSF_CTRL_ON_BIT]; // RL10
            stop_in_idle <= CTRL_RESET[`APSF_CTRL_SIDL_BIT];
            read_format_sel <=
                CTRL_RESET[`APSF_CTRL_FMT_HI:`APSF_CTRL_FMT_LO];
            samp <= CTRL_RESET[`APSF_CTRL_SAMP_BIT];
            done <= CTRL_RESET[`APSF_CTRL_DONE_BIT];
            rc_clock_select <= CFG_RESET[`APSF_CFG_RC_BIT];
            mux_a_channel_sel <=
                CFG_RESET[`APSF_CFG_CH_HI:`APSF_CFG_CH_LO];
            analog_pin_config <= `APSF_PINCFG_RST;
        end else if (clk_en) begin
            if (wr_ctrl) begin
                converter_on <= reg_wdata[`APSF_CTRL_ON_BIT]; // RL1
                stop_in_idle <= reg_wdata[`APSF_CTRL_SIDL_BIT];
                read_format_sel <=
                    reg_wdata[`APSF_CTRL_FMT_HI:`APSF_CTRL_FMT_LO]; // RL12
                samp <= reg_wdata[`APSF_CTRL_SAMP_BIT];
            end else if (state == ST_SAMPLE && conv_trigger) begin
                samp <= 1'b0;
            end
            // Completion set beats a software clear in the same cycle
            if (next_done_evt) begin
                done <= 1'b1; // RL7
            end else if (wr_ctrl) begin
                done <= reg_wdata[`APSF_CTRL_DONE_BIT];
            end
            if (wr_cfg) begin
                rc_clock_select <= reg_wdata[`APSF_CFG_RC_BIT];
                mux_a_channel_sel <=
                    reg_wdata[`APSF_CFG_CH_HI:`APSF_CFG_CH_LO];
            end
            if (wr_pincfg) begin
                analog_pin_config <= reg_wdata;
            end
        end
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE; // RL10
            tad_count <= 4'h0;
            wr_ptr <= 4'h0;
            sleep_off <= 1'b0;
            wake_req <= 1'b0;
            done_pulse <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            tad_count <= next_tad_count;
            done_pulse <= next_done_evt;
            wake_req <= next_done_evt && cpu_sleep && irq_enable; // RL8
            if (next_done_evt) begin
                wr_ptr <= wr_ptr + 4'h1;
            end
            // Power-down lasts until Sleep ends or software turns off
            if (!cpu_sleep || !converter_on) begin
                sleep_off <= 1'b0;
            end else if (next_done_evt && !irq_enable) begin
                sleep_off <= 1'b1; // RL8
            end
        end
    end

    // No reset on the buffer array so results survive a device reset
    always @(posedge ref_clk) begin
        if (clk_en) begin
            if (buf_wr_en) begin
                result_buffer[buf_wr_index] <= buf_wr_data;
            end
        end
    end // RL11

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            analog_power_en <= 1'b0;
            hold_capacitor <= 1'b0;
            conv_clk <= 1'b0;
            channel_sel <= 4'h0;
        end else if (clk_en) begin
            analog_power_en <= active; // RL1
            hold_capacitor <= (next_state == ST_SAMPLE);
            channel_sel <= mux_a_channel_sel;
            if (next_state != ST_CONVERT || sleep_gated || idle_halt) begin
                conv_clk <= 1'b0; // RL3
            end else if (conv_tick) begin
                conv_clk <= !conv_clk;
            end
        end
    end

    // Built from the field positions so a layout change stays in one place
    always @* begin
        ctrl_word = 16'h0000;
        ctrl_word[`APSF_CTRL_ON_BIT] = converter_on;
        ctrl_word[`APSF_CTRL_SIDL_BIT] = stop_in_idle;
        ctrl_word[`APSF_CTRL_FMT_HI:`APSF_CTRL_FMT_LO] = read_format_sel;
        ctrl_word[`APSF_CTRL_SAMP_BIT] = samp;
        ctrl_word[`APSF_CTRL_DONE_BIT] = done;
        cfg_word = 16'h0000;
        cfg_word[`APSF_CFG_RC_BIT] = rc_clock_select;
        cfg_word[`APSF_CFG_CH_HI:`APSF_CFG_CH_LO] = mux_a_channel_sel;
    end

    apsf_fmt u_fmt (
        .raw(result_buffer[reg_addr[3:0]]),
        .read_format_sel(read_format_sel),
        .bus_word(fmt_word)
    );

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (clk_en) begin
            if (reg_rd) begin
                if (is_buf_addr(reg_addr)) begin
                    reg_rdata <= fmt_word; // RL13
                end else if (reg_addr == `APSF_REG_CTRL) begin
                    reg_rdata <= ctrl_word;
                end else if (reg_addr == `APSF_REG_CFG) begin
                    reg_rdata <= cfg_word;
                end else if (reg_addr == `APSF_REG_PINCFG) begin
                    reg_rdata <= analog_pin_config;
                end else if (reg_addr == `APSF_REG_PORT) begin
                    reg_rdata <= pin_s2 & analog_pin_config; // RL15
                end else begin
                    reg_rdata <= 16'h0000;
                end
            end else begin
                reg_rdata <= 16'h0000;
            end
        end
    end

endmodule

// [sim/apsf_core_model.sv]
`timescale 1ns/1ps
module apsf_core_model (
    input wire ref_clk,
    input wire rst,
    output reg tcy_tick,
    output reg rc_osc
);
    reg [1:0] div;
    // One instruction strobe every four system clocks
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div <= 2'h0;
            tcy_tick <= 1'b0;
        end else begin
            div <= div + 2'h1;
            tcy_tick <= (div == 2'h3);
        end
    end
    // Free-running RC source, period unrelated to the system clock
    initial begin
        rc_osc = 1'b0;
        forever #33 rc_osc = ~rc_osc;
    end
endmodule

// [sim/apsf_ctrl_assertions.sv]
`timescale 1ns/1ps
`include "apsf_consts.vh"
module apsf_ctrl_assertions (
    input wire ref_clk,
    input wire rst,
    input wire clk_en,
    input wire [4:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    input wire cpu_sleep,
    input wire cpu_idle,
    input wire irq_enable,
    input wire analog_power_en,
    input wire hold_capacitor,
    input wire conv_clk,
    input wire done_pulse,
    input wire wake_req
);
    reg on_q;
    reg sidl_q;
    reg rc_q;
    reg [15:0] pin_q;
    // Shadow of the control bits, since the checker sees only ports
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            on_q <= 1'b0;
            sidl_q <= 1'b0;
            rc_q <= 1'b0;
            pin_q <= 16'h0000;
        end else if (clk_en && reg_wr) begin
            if (reg_addr == `APSF_REG_CTRL) begin
                on_q <= reg_wdata[15];
                sidl_q <= reg_wdata[13];
            end
            if (reg_addr == `APSF_REG_CFG)
                rc_q <= reg_wdata[7];
            if (reg_addr == `APSF_REG_PINCFG)
                pin_q <= reg_wdata;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_off_no_done: assert property (
        done_pulse |-> $past(analog_power_en))
        else $error("completion while converter off");
    a_wake_has_cause: assert property (
        wake_req |-> done_pulse && $past(cpu_sleep) && $past(irq_enable))
        else $error("wake without sleep completion");
    a_wake_when_due: assert property (
        done_pulse && $past(cpu_sleep) && $past(irq_enable) |-> wake_req)
        else $error("missing wake after sleep completion");
    a_sleep_clk_low: assert property (
        cpu_sleep && $past(cpu_sleep) && !rc_q && !$past(rc_q)
        |-> !conv_clk && !done_pulse)
        else $error("converter clock running in sleep");
    a_hold_needs_power: assert property (
        hold_capacitor |-> analog_power_en)
        else $error("sampling while unpowered");
    a_idle_freeze: assert property (
        cpu_idle && $past(cpu_idle) && sidl_q && $past(sidl_q)
        |-> !conv_clk && !done_pulse)
        else $error("converter active in idle");
    a_off_no_power: assert property (
        !on_q && !$past(on_q) |-> !analog_power_en && !hold_capacitor)
        else $error("powered while off");
    a_port_analog_zero: assert property (
        $past(clk_en) && $past(reg_rd) &&
        $past(reg_addr) == `APSF_REG_PORT
        |-> (reg_rdata & ~$past(pin_q)) == 16'h0000)
        else $error("analog pin read as one");
endmodule
bind apsf_ctrl apsf_ctrl_assertions chk_u (.ref_clk(ref_clk), .rst(rst),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cpu_sleep(cpu_sleep), .cpu_idle(cpu_idle), .irq_enable(irq_enable),
    .analog_power_en(analog_power_en), .hold_capacitor(hold_capacitor),
    .conv_clk(conv_clk), .done_pulse(done_pulse), .wake_req(wake_req));

// [sim/apsf_ctrl_tb.sv]
`timescale 1ns/1ps
`include "apsf_consts.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
    err_count++; $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module apsf_ctrl_tb;
    reg ref_clk = 1'b0;
    reg rst = 1'b1;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg conv_trigger = 1'b0;
    reg cpu_sleep = 1'b0;
    reg cpu_idle = 1'b0;
    reg irq_enable = 1'b0;
    reg [4:0] reg_addr = 5'h00;
    reg [15:0] reg_wdata = 16'h0000;
    reg [15:0] port_pins = 16'h0000;
    reg [11:0] conv_result = 12'h123;
    wire tcy_tick, rc_osc, analog_power_en, hold_capacitor, conv_clk;
    wire done_pulse, wake_req;
    wire [3:0] channel_sel;
    wire [15:0] reg_rdata;
    logic [15:0] ftab [4] = '{16'h0A5C, 16'hFA5C, 16'hA5C0, 16'hA5C0};
    integer err_count = 0;
    integer total_checks = 0;
    integer i;
    reg hit, woke;
    apsf_core_model core_u (.ref_clk(ref_clk), .rst(rst),
        .tcy_tick(tcy_tick), .rc_osc(rc_osc));
    apsf_ctrl dut_u (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tcy_tick(tcy_tick),
        .rc_osc(rc_osc), .cpu_sleep(cpu_sleep), .cpu_idle(cpu_idle),
        .irq_enable(irq_enable), .conv_trigger(conv_trigger),
        .conv_result(conv_result), .port_pins(port_pins),
        .analog_power_en(analog_power_en), .hold_capacitor(hold_capacitor),
        .conv_clk(conv_clk), .channel_sel(channel_sel),
        .done_pulse(done_pulse), .wake_req(wake_req));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task end_of_test;
        begin
            if (err_count == 0 && total_checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task wr(input [4:0] a, input [15:0] d);
        begin
            @(posedge ref_clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge ref_clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rdc(input [4:0] a, input [15:0] e);
        begin
            @(posedge ref_clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge ref_clk);
            reg_rd <= 1'b0;
            @(posedge ref_clk);
            `CHK(reg_rdata, e)
        end
    endtask
    // A missed completion ends the run, since later steps depend on it
    task wait_done(input integer n, input reg e);
        begin
            hit = 1'b0;
            woke = 1'b0;
            for (i = 0; i < n && !hit; i++) begin
                @(posedge ref_clk);
                hit = (done_pulse === 1'b1);
                woke = (wake_req === 1'b1);
            end
            `CHK(hit, e)
            if (e && !hit)
                end_of_test;
        end
    endtask
    task convert(input [15:0] c);
        begin
            wr(`APSF_REG_CTRL, c | 16'h0002);
            repeat (20) @(posedge ref_clk);
            wr(`APSF_REG_CTRL, c);
        end
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        rdc(`APSF_REG_CTRL, 16'h0000);
        rdc(`APSF_REG_CFG, 16'h0000);
        rdc(5'h1F, 16'h0000);
        wr(5'h03, 16'hFA5C);
        for (int j = 0; j < 4; j++) begin
            wr(`APSF_REG_CTRL, {6'h00, j[1:0], 8'h00});
            rdc(5'h03, ftab[j]);
        end
        wr(`APSF_REG_PINCFG, 16'h00F0);
        port_pins <= 16'h0FFF;
        wr(`APSF_REG_PORT, 16'hFFFF);
        rdc(`APSF_REG_PORT, 16'h00F0);
        wr(`APSF_REG_CFG, 16'h0002);
        wr(`APSF_REG_CTRL, 16'h8002);
        repeat (20) @(posedge ref_clk);
        conv_trigger <= 1'b1;
        @(posedge ref_clk);
        conv_trigger <= 1'b0;
        wait_done(200, 1'b1);
        rdc(`APSF_REG_CTRL, 16'h8001);
        rdc(5'h00, 16'h0123);
        wr(`APSF_REG_CFG, 16'h0005);
        convert(16'h8000);
        `CHK(channel_sel, 4'h5)
        wait_done(200, 1'b1);
        rdc(5'h01, 16'h0000);
        // Off or Sleep in mid-conversion must leave the old word in place
        wr(5'h02, 16'h0055);
        wr(`APSF_REG_CFG, 16'h0002);
        convert(16'h8000);
        wr(`APSF_REG_CTRL, 16'h0000);
        wr(`APSF_REG_CTRL, 16'h0002);
        wait_done(150, 1'b0);
        convert(16'h8000);
        cpu_sleep <= 1'b1;
        repeat (5) @(posedge ref_clk);
        cpu_sleep <= 1'b0;
        wait_done(150, 1'b0);
        rdc(`APSF_REG_CTRL, 16'h8000);
        rdc(5'h02, 16'h0055);
        wr(`APSF_REG_CFG, 16'h0082);
        irq_enable <= 1'b1;
        convert(16'h8000);
        cpu_sleep <= 1'b1;
        wait_done(1000, 1'b1);
        `CHK(woke, 1'b1)
        cpu_sleep <= 1'b0;
        rdc(5'h02, 16'h0123);
        irq_enable <= 1'b0;
        convert(16'h8000);
        cpu_sleep <= 1'b1;
        wait_done(1000, 1'b1);
        `CHK(woke, 1'b0)
        repeat (2) @(posedge ref_clk);
        `CHK(analog_power_en, 1'b0)
        cpu_sleep <= 1'b0;
        rdc(`APSF_REG_CTRL, 16'h8001);
        wr(`APSF_REG_CFG, 16'h0002);
        convert(16'hA000);
        cpu_idle <= 1'b1;
        wait_done(150, 1'b0);
        cpu_idle <= 1'b0;
        wait_done(200, 1'b1);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rdc(`APSF_REG_CTRL, 16'h0000);
        rdc(5'h00, 16'h0123);
        end_of_test;
    end
endmodule
